// File: hw/fifo_level_setting_cmp.sv
// FIFO threshold comparator: maps the 4-bit setting to byte counts.
// Assumes byte counts arrive from logic on the same clock.
`timescale 1ns/1ps
module fifo_level_setting_cmp
    import cfg_regs_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Threshold link
    thr_if.cmp        t
);
    function automatic logic [6:0] tx_thr(input logic [3:0] n);
        tx_thr = TX_THR_BASE - THR_STEP * {3'h0, n};
    endfunction

    function automatic logic [6:0] rx_thr(input logic [3:0] n);
        rx_thr = THR_STEP * ({3'h0, n} + 7'h01);
    endfunction

    // Registered so the flags are clean data outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            t.tx_over <= 1'b0;
            t.rx_over <= 1'b0;
        end else begin
            t.tx_over <= t.tx_count >= tx_thr(t.level);
            t.rx_over <= t.rx_count >= rx_thr(t.level);
        end
    end
endmodule

// File: hw/pin0_fifo_threshold_sync_regs.sv
// Register bank for pin 0 configuration, FIFO thresholds and sync word.
// Assumes the serial port front end delivers decoded, single-cycle
// write strobes and read addresses synchronous to clk.
`timescale 1ns/1ps
module pin0_fifo_threshold_sync_regs
    import cfg_regs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic        wr_en,
    input  wire logic [5:0]  addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    // Signals offered to pin zero, indexed by select code
    input  wire logic [63:0] pin_sources,
    output logic             general_output_pin_zero,
    output logic             temp_sensor_on,
    // FIFO levels and threshold flags
    input  wire logic [6:0]  tx_bytes,
    input  wire logic [6:0]  rx_bytes,
    output logic             tx_thr_exceeded,
    output logic             rx_thr_exceeded,
    // Sync word to the detector
    output logic      [15:0] sync_word
);
    logic [7:0] output_pin_zero_config_q;
    logic [3:0] fifo_level_setting_q;
    logic [7:0] sync_word_high_q;
    logic [7:0] sync_word_low_q;
    logic       pin_zero_polarity_flip;
    logic [5:0] pin_zero_signal_select;
    logic       pin_d;
    thr_if      thr ();

    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        hit = wr_en && (a == o);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_pin_zero_config_q <= RST_PIN0_CFG;
        end else if (hit(addr, OFS_PIN0_CFG)) begin
            // Stored as written; sensor mode needs the host to clear
            // the rest, as nothing in the bank gates pin routing in sensor mode
            output_pin_zero_config_q <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_level_setting_q <= RST_FIFO_LEVEL_SETTING[LEVEL_MSB:0];
        end else if (hit(addr, OFS_FIFO_LEVEL_SETTING)) begin
            // Upper nibble is not stored, so it always reads back zero
            fifo_level_setting_q <= wdata[LEVEL_MSB:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_word_high_q <= RST_SYNC_HIGH;
        end else if (hit(addr, OFS_SYNC_HIGH)) begin
            sync_word_high_q <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_word_low_q <= RST_SYNC_LOW;
        end else if (hit(addr, OFS_SYNC_LOW)) begin
            sync_word_low_q <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        unique case (addr)
            OFS_PIN0_CFG:  rdata = output_pin_zero_config_q;
            OFS_FIFO_LEVEL_SETTING:  rdata = {4'h0, fifo_level_setting_q};
            OFS_SYNC_HIGH: rdata = sync_word_high_q;
            OFS_SYNC_LOW:  rdata = sync_word_low_q;
            default:       rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Pin zero routing

    assign pin_zero_polarity_flip =
        output_pin_zero_config_q[POL_FLIP_BIT];
    assign pin_zero_signal_select =
        output_pin_zero_config_q[SEL_MSB:0];
    // Select code 63 (reset) is the divided crystal clock, supplied
    // on the matching pin_sources line by the clock tree
    assign pin_d = pin_sources[pin_zero_signal_select]
                 ^ pin_zero_polarity_flip;

    // Registered output avoids glitches from the mux
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            general_output_pin_zero <= 1'b0;
        end else begin
            general_output_pin_zero <= pin_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            temp_sensor_on <= 1'b0;
        end else begin
            temp_sensor_on <= output_pin_zero_config_q[TEMP_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Threshold comparison and sync word

    assign thr.level    = fifo_level_setting_q;
    assign thr.tx_count = tx_bytes;
    assign thr.rx_count = rx_bytes;

    fifo_level_setting_cmp u_cmp (
        .clk (clk),
        .rst (rst),
        .t   (thr.cmp)
    );

    assign tx_thr_exceeded = thr.tx_over;
    assign rx_thr_exceeded = thr.rx_over;
    assign sync_word = {sync_word_high_q, sync_word_low_q};

    ////////////////////////////////////////////////////////////////////
    // Checks
    // Write strobes are spelled out instead of calling hit(): its body
    // reads wr_en live rather than sampled and would miss every write

    chk_sync_reset_value: assert property (
        @(posedge clk) $rose(!rst) |->
        sync_word == {RST_SYNC_HIGH, RST_SYNC_LOW}
    ) else $error("sync word reset value wrong");

    chk_sync_high_write: assert property (
        @(posedge clk) disable iff (rst)
        wr_en && addr == OFS_SYNC_HIGH |=> sync_word[15:8] == $past(wdata)
    ) else $error("sync high byte not stored");

    chk_sync_low_write: assert property (
        @(posedge clk) disable iff (rst)
        wr_en && addr == OFS_SYNC_LOW |=> sync_word[7:0] == $past(wdata)
    ) else $error("sync low byte not stored");

    chk_thr_reserved_zero: assert property (
        @(posedge clk) disable iff (rst)
        addr == OFS_FIFO_LEVEL_SETTING |-> rdata[7:4] == 4'h0
    ) else $error("reserved threshold bits not zero");

    chk_tx_thr_compare: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> tx_thr_exceeded == ($past(tx_bytes) >=
        7'h3d - 7'h04 * {3'h0, $past(fifo_level_setting_q)})
    ) else $error("tx threshold flag wrong");

    chk_rx_thr_compare: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> rx_thr_exceeded == ($past(rx_bytes) >=
        7'h04 * ({3'h0, $past(fifo_level_setting_q)} + 7'h01))
    ) else $error("rx threshold flag wrong");

    chk_pin_polarity: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> general_output_pin_zero ==
        ($past(pin_sources[pin_zero_signal_select]) ^
         $past(output_pin_zero_config_q[POL_FLIP_BIT]))
    ) else $error("pin zero polarity wrong");

    chk_pin_cfg_reset: assert property (
        @(posedge clk)
        rst |=> rst || output_pin_zero_config_q == 8'h3f
    ) else $error("pin zero select reset wrong");

    chk_temp_enable: assert property (
        @(posedge clk) disable iff (rst)
        (wr_en && addr == OFS_PIN0_CFG) ##1 !(wr_en && addr == OFS_PIN0_CFG)
        |=> temp_sensor_on == $past(wdata[TEMP_EN_BIT], 2)
    ) else $error("temp sensor enable not followed");

    chk_pin_cfg_write: assert property (
        @(posedge clk) disable iff (rst)
        wr_en && addr == OFS_PIN0_CFG |=>
        output_pin_zero_config_q == $past(wdata)
    ) else $error("pin zero config not stored");

    chk_level_write: assert property (
        @(posedge clk) disable iff (rst)
        wr_en && addr == OFS_FIFO_LEVEL_SETTING |=>
        fifo_level_setting_q == $past(wdata[LEVEL_MSB:0])
    ) else $error("threshold setting not stored");

    chk_sync_high_read: assert property (
        @(posedge clk) disable iff (rst)
        addr == OFS_SYNC_HIGH |-> rdata == sync_word[15:8]
    ) else $error("sync high readback differs");

    chk_sync_low_read: assert property (
        @(posedge clk) disable iff (rst)
        addr == OFS_SYNC_LOW |-> rdata == sync_word[7:0]
    ) else $error("sync low readback differs");

    // Checked one edge after a sampled reset so the power-up race on
    // the first edge cannot show an unknown flag
    chk_flags_reset: assert property (
        @(posedge clk)
        rst |=> !tx_thr_exceeded && !rx_thr_exceeded
    ) else $error("threshold flags not cleared in reset");

    chk_pin_reset_low: assert property (
        @(posedge clk)
        rst |=> !general_output_pin_zero && !temp_sensor_on
    ) else $error("pin zero outputs not cleared in reset");
endmodule

// File: inc/cfg_regs_pkg.sv
// Package for the pin 0, FIFO threshold and sync word register bank.
// Assumes a byte-wide register port with 6-bit addresses.
package cfg_regs_pkg;
    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 8;
    localparam int          FIFO_CNT_W      = 7;

    // Register offsets
    localparam logic [5:0]  OFS_PIN0_CFG    = 6'h02;
    localparam logic [5:0]  OFS_FIFO_LEVEL_SETTING    = 6'h03;
    localparam logic [5:0]  OFS_SYNC_HIGH   = 6'h04;
    localparam logic [5:0]  OFS_SYNC_LOW    = 6'h05;

    // Reset values
    localparam logic [7:0]  RST_PIN0_CFG    = 8'h3f;
    localparam logic [7:0]  RST_FIFO_LEVEL_SETTING    = 8'h07;
    localparam logic [7:0]  RST_SYNC_HIGH   = 8'hd3;
    localparam logic [7:0]  RST_SYNC_LOW    = 8'h91;

    // Field positions
    localparam int          TEMP_EN_BIT     = 7;
    localparam int          POL_FLIP_BIT    = 6;
    localparam int          SEL_MSB         = 5;
    localparam int          SEL_W           = 6;
    localparam int          LEVEL_MSB       = 3;
    localparam int          LEVEL_W         = 4;

    // Threshold mapping: tx = 61 - 4n, rx = 4(n+1)
    localparam logic [6:0]  TX_THR_BASE     = 7'h3d;
    localparam logic [6:0]  THR_STEP        = 7'h04;
endpackage

// File: inc/thr_if.sv
// Interface carrying the threshold setting to the comparator and
// the two exceeded flags back. Same clock domain as the register bank.
`timescale 1ns/1ps
interface thr_if;
    logic [3:0] level;
    logic [6:0] tx_count;
    logic [6:0] rx_count;
    logic       tx_over;
    logic       rx_over;
    modport bank (output level, output tx_count, output rx_count,
                  input tx_over, input rx_over);
    modport cmp  (input level, input tx_count, input rx_count,
                  output tx_over, output rx_over);
endinterface

// File: tb/host_model.sv
// Host model: byte writes and combinational reads of the register bank.
// Assumes the bank takes wr_en, addr and wdata on the rising clk edge.
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic            wr_en,
    output logic      [5:0] addr,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial begin
        wr_en = 1'b0;
        addr  = 6'h00;
        wdata = 8'h00;
    end
    // Raw write; scenarios go through cfg so the host duties hold
    task automatic put(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        // Released data shows the inverse, so a stale copy cannot pass
        wdata <= ~d;
    endtask
    // Write that keeps the host duties on shared and reserved bits
    task automatic cfg(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 6'h02 && d[7]) v = 8'h80;
        if (a == 6'h03) v[7:4] = 4'h0;
        put(a, v);
    endtask
    task automatic get(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        #1;
        d = rdata;
    endtask
endmodule

// File: tb/pin0_fifo_threshold_sync_regs_tb_top.sv
// Testbench: host model writes and reads; bench drives pin sources and
// FIFO byte counts. Assumes one clock and the bank's 1-cycle latencies.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module pin0_fifo_threshold_sync_regs_tb_top
    import cfg_regs_pkg::*;
;
    logic        clk, rst, wr_en, pin, temp, tx_ov, rx_ov;
    logic [5:0]  addr;
    logic [7:0]  wdata, rdata, rd;
    logic [63:0] pin_sources;
    logic [6:0]  tx_bytes, rx_bytes;
    logic [15:0] sync_word;
    int          error_cnt, compares;

    pin0_fifo_threshold_sync_regs pin0_fifo_threshold_sync_regs_i (
        .clk(clk), .rst(rst), .wr_en(wr_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .pin_sources(pin_sources),
        .general_output_pin_zero(pin), .temp_sensor_on(temp),
        .tx_bytes(tx_bytes), .rx_bytes(rx_bytes),
        .tx_thr_exceeded(tx_ov), .rx_thr_exceeded(rx_ov),
        .sync_word(sync_word));
    host_model host_model_i (.clk(clk), .wr_en(wr_en), .addr(addr),
        .wdata(wdata), .rdata(rdata));

    always #4 clk = ~clk;

    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Derived outputs are registered: look one edge after driving
    task automatic pin_chk(input logic [63:0] src, input logic exp);
        @(posedge clk);
        pin_sources <= src;
        @(posedge clk);
        #1;
        `CHK(pin, exp)
    endtask
    task automatic thr_chk(input int tx, input int rx, input logic e);
        @(posedge clk);
        tx_bytes <= 7'(tx);
        rx_bytes <= 7'(rx);
        @(posedge clk);
        #1;
        `CHK({tx_ov, rx_ov}, {e, e})
    endtask
    task automatic t_reset();
        host_model_i.get(OFS_PIN0_CFG, rd);
        `CHK(rd, 8'h3f)
        host_model_i.get(OFS_FIFO_LEVEL_SETTING, rd);
        `CHK(rd, 8'h07)
        host_model_i.get(6'h06, rd);
        `CHK(rd, 8'h00)
        `CHK(sync_word, 16'hd391)
        pin_chk(64'h8000_0000_0000_0000, 1'b1);
        pin_chk(64'h7fff_ffff_ffff_ffff, 1'b0);
    endtask
    task automatic t_pin();
        host_model_i.cfg(OFS_PIN0_CFG, 8'h45);
        pin_chk(64'h0000_0000_0000_0020, 1'b0);
        pin_chk(64'hffff_ffff_ffff_ffdf, 1'b1);
        host_model_i.cfg(OFS_PIN0_CFG, 8'h05);
        pin_chk(64'h0000_0000_0000_0020, 1'b1);
        `CHK(temp, 1'b0)
        host_model_i.cfg(OFS_PIN0_CFG, 8'hc5);
        pin_chk(64'h0000_0000_0000_0001, 1'b1);
        `CHK(temp, 1'b1)
        host_model_i.get(OFS_PIN0_CFG, rd);
        `CHK(rd, 8'h80)
    endtask
    task automatic t_thr();
        for (int n = 0; n < 16; n++) begin
            // Host clears the reserved bits; they must read back as zero
            host_model_i.cfg(OFS_FIFO_LEVEL_SETTING, {4'ha, 4'(n)});
            host_model_i.get(OFS_FIFO_LEVEL_SETTING, rd);
            `CHK(rd, {4'h0, 4'(n)})
            thr_chk(61 - 4 * n, 4 * (n + 1), 1'b1);
            thr_chk(60 - 4 * n, 4 * n + 3, 1'b0);
        end
    endtask
    task automatic t_sync();
        host_model_i.cfg(OFS_SYNC_HIGH, 8'haa);
        host_model_i.cfg(OFS_SYNC_LOW, 8'h55);
        #1;
        `CHK(sync_word, 16'haa55)
        host_model_i.get(OFS_SYNC_HIGH, rd);
        `CHK(rd, 8'haa)
        host_model_i.get(OFS_SYNC_LOW, rd);
        `CHK(rd, 8'h55)
    endtask
    task automatic t_rst_again();
        // Earlier writes moved every register off its reset value
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(sync_word, {RST_SYNC_HIGH, RST_SYNC_LOW})
        `CHK({pin, temp, tx_ov, rx_ov}, 4'h0)
        host_model_i.get(OFS_FIFO_LEVEL_SETTING, rd);
        `CHK(rd, RST_FIFO_LEVEL_SETTING)
        host_model_i.get(OFS_PIN0_CFG, rd);
        `CHK(rd, RST_PIN0_CFG)
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        pin_sources = 64'h0;
        tx_bytes = 7'h00;
        rx_bytes = 7'h00;
        error_cnt = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pin();
        t_thr();
        t_sync();
        t_rst_again();
        close_out();
    end
    // Hang guard: the run is far shorter than this bound
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
endmodule
